/* design/dsl_ctrl_regs.sv */
// Purpose: upper control registers, converter source select, write latch
// Assumes: byte port from serial logic; one access per cycle
// Notes:   table memory is outside; this block only forms its addresses
`timescale 1ns/1ns
`include "dsl_cfg.svh"
module dsl_ctrl_regs
  import dsl_pkg::*;
#(
  parameter int DAT_W = 8,
  parameter int ROW_W = 6
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // register port from the serial interface
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_wr_ack,
  // write gate for the rest of the memory
  output logic                  write_gate_latch,
  // lower control fields
  input  wire logic             ctrl_volatility_sel,
  input  wire logic [ROW_W-1:0] table1_direct_row,
  input  wire logic [ROW_W-1:0] table2_direct_row,
  input  wire logic [DAT_W-1:0] conv1_direct_byte,
  // adc result
  input  wire logic [DAT_W-1:0] adc_result_bits,
  // table memory read ports
  output logic      [DAT_W-1:0] table_one_addr,
  input  wire logic [DAT_W-1:0] table_one_data,
  output logic      [DAT_W-1:0] table_two_addr,
  input  wire logic [DAT_W-1:0] table_two_data,
  // converter inputs and ranges
  output logic      [DAT_W-1:0] conv1_in,
  output logic      [DAT_W-1:0] conv2_in,
  output dsl_range_t            out1_range,
  output dsl_range_t            out2_range,
  // volatile byte must be saved when volatility bit is set
  output logic                  conv2_byte_persist
);
  if (DAT_W != 8) begin : g_bad_dat
    $error("register port is byte wide");
  end
  if (ROW_W != 6) begin : g_bad_row
    $error("tables hold sixty-four rows");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] conv2_byte;
    logic [7:0] select;
    logic [6:0] latch_rsvd;
    logic       latch;
    logic       wr_ack;
    logic [7:0] rdata;
  } dsl_state_t;

  dsl_state_t cur_ff;
  dsl_state_t nxt_ff;

  logic conv2_direct_sel;
  logic conv1_direct_sel;
  logic table1_direct_row_sel;
  logic table2_direct_row_sel;
  logic out1_range_hi;
  logic out1_range_lo;
  logic out2_range_hi;
  logic out2_range_lo;
  logic is_rsvd;

  assign conv2_direct_sel      = cur_ff.select[`DSL_BIT_CONV2_SEL];
  assign table2_direct_row_sel = cur_ff.select[`DSL_BIT_TABLE2_SEL];
  assign conv1_direct_sel      = cur_ff.select[`DSL_BIT_CONV1_SEL];
  assign table1_direct_row_sel = cur_ff.select[`DSL_BIT_TABLE1_SEL];
  assign out2_range_hi         = cur_ff.select[`DSL_BIT_OUT2_HI];
  assign out2_range_lo         = cur_ff.select[`DSL_BIT_OUT2_LO];
  assign out1_range_hi         = cur_ff.select[`DSL_BIT_OUT1_HI];
  assign out1_range_lo         = cur_ff.select[`DSL_BIT_OUT1_LO];

  // reserved window: no register, reads zero, writes dropped
  assign is_rsvd = (reg_addr >= `DSL_OFS_RSVD_LO) &&
                   (reg_addr <= `DSL_OFS_RSVD_HI);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_ff        = cur_ff;
    nxt_ff.wr_ack = 1'b0;
    if (reg_wr) begin
      // ack only while the latch is set; a cleared latch aborts
      nxt_ff.wr_ack = cur_ff.latch;
      // latch register takes its own writes even when cleared
      if (reg_addr == `DSL_OFS_LATCH) begin
        nxt_ff.wr_ack = 1'b1;
        if (reg_wdata == `DSL_LATCH_SET_VAL) begin
          nxt_ff.latch = 1'b1;
        end else if (reg_wdata == `DSL_LATCH_CLR_VAL) begin
          nxt_ff.latch = 1'b0;
        end
        // reserved bits untouched by latch writes
        nxt_ff.latch_rsvd = cur_ff.latch_rsvd;
      end else if (cur_ff.latch && !is_rsvd) begin
        if (reg_addr == `DSL_OFS_CONV2_BYTE) begin
          nxt_ff.conv2_byte = reg_wdata;
        end
        if (reg_addr == `DSL_OFS_SELECT) begin
          nxt_ff.select = reg_wdata;
        end
      end
    end
    nxt_ff.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `DSL_OFS_CONV2_BYTE: nxt_ff.rdata = cur_ff.conv2_byte;
        `DSL_OFS_SELECT:     nxt_ff.rdata = cur_ff.select;
        `DSL_OFS_LATCH:      nxt_ff.rdata = {cur_ff.latch,
                                             cur_ff.latch_rsvd};
        `DSL_OFS_ADC:        nxt_ff.rdata = adc_result_bits;
        default:             nxt_ff.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      // latch always comes up cleared, writes disabled
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------------
  // converter source selection
  // ----------------------------------------------------------------------
  dsl_row_mux #(.ROW_W(ROW_W), .DAT_W(DAT_W)) u_mux1 (
    .row_direct  (table1_direct_row_sel),
    .byte_direct (conv1_direct_sel),
    .adc_value   (adc_result_bits),
    .direct_row  (table1_direct_row),
    .direct_byte (conv1_direct_byte),
    .table_base  (`DSL_TABLE1_BASE),
    .table_data  (table_one_data),
    .table_addr  (table_one_addr),
    .conv_in     (conv1_in)
  );

  dsl_row_mux #(.ROW_W(ROW_W), .DAT_W(DAT_W)) u_mux2 (
    .row_direct  (table2_direct_row_sel),
    .byte_direct (conv2_direct_sel),
    .adc_value   (adc_result_bits),
    .direct_row  (table2_direct_row),
    .direct_byte (cur_ff.conv2_byte),
    .table_base  (`DSL_TABLE2_BASE),
    .table_data  (table_two_data),
    .table_addr  (table_two_addr),
    .conv_in     (conv2_in)
  );

  assign out1_range         = dsl_range_t'({out1_range_hi, out1_range_lo});
  assign out2_range         = dsl_range_t'({out2_range_hi, out2_range_lo});
  assign reg_rdata          = cur_ff.rdata;
  assign reg_wr_ack         = cur_ff.wr_ack;
  assign write_gate_latch   = cur_ff.latch;
  assign conv2_byte_persist = ctrl_volatility_sel;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_nack_when_closed;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && !cur_ff.latch && reg_addr != `DSL_OFS_LATCH)
        |=> !reg_wr_ack;
  endproperty
  a_nack_when_closed: assert property (p_nack_when_closed)
    else $error("write acked while latch clear");

  property p_no_store_closed;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && !cur_ff.latch && reg_addr == `DSL_OFS_SELECT)
        |=> $stable(cur_ff.select);
  endproperty
  a_no_store_closed: assert property (p_no_store_closed)
    else $error("select changed while latch clear");

  property p_latch_set;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `DSL_OFS_LATCH &&
       reg_wdata == `DSL_LATCH_SET_VAL) |=> write_gate_latch;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch not set by set value");

  property p_latch_clr;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `DSL_OFS_LATCH &&
       reg_wdata == `DSL_LATCH_CLR_VAL) |=> !write_gate_latch;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch not cleared by clear value");

  property p_latch_reset;
    @(posedge core_clk) srst |=> !write_gate_latch;
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("latch set after reset");

  property p_rsvd_stable;
    @(posedge core_clk) disable iff (srst)
      ##1 cur_ff.latch_rsvd == 7'h00;
  endproperty
  a_rsvd_stable: assert property (p_rsvd_stable)
    else $error("latch reserved bits changed");

  property p_conv2_direct;
    @(posedge core_clk) disable iff (srst)
      conv2_direct_sel |-> conv2_in == cur_ff.conv2_byte;
  endproperty
  a_conv2_direct: assert property (p_conv2_direct)
    else $error("converter two not fed from direct byte");

  property p_conv2_table;
    @(posedge core_clk) disable iff (srst)
      !conv2_direct_sel |-> conv2_in == table_two_data;
  endproperty
  a_conv2_table: assert property (p_conv2_table)
    else $error("converter two not fed from table");

  property p_row_addr;
    @(posedge core_clk) disable iff (srst)
      !table1_direct_row_sel |->
        table_one_addr == (`DSL_TABLE1_BASE + {2'b00, adc_result_bits[7:2]});
  endproperty
  a_row_addr: assert property (p_row_addr)
    else $error("table one row not from adc");

  property p_rsvd_read;
    @(posedge core_clk) disable iff (srst)
      (reg_rd && is_rsvd) |=> reg_rdata == 8'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved address read nonzero");

  property p_ack_latch_reg;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `DSL_OFS_LATCH)
        |=> reg_wr_ack;
  endproperty
  a_ack_latch_reg: assert property (p_ack_latch_reg)
    else $error("latch register write not acked");

  property p_ack_when_open;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && cur_ff.latch)
        |=> reg_wr_ack;
  endproperty
  a_ack_when_open: assert property (p_ack_when_open)
    else $error("write not acked while latch set");

  property p_ack_pulse;
    @(posedge core_clk) disable iff (srst)
      !reg_wr
        |=> !reg_wr_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack without a write");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (srst)
      !reg_rd
        |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero between reads");

  property p_latch_hold;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `DSL_OFS_LATCH &&
       reg_wdata != `DSL_LATCH_SET_VAL && reg_wdata != `DSL_LATCH_CLR_VAL)
        |=> $stable(write_gate_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch moved by other value");

  property p_latch_keep;
    @(posedge core_clk) disable iff (srst)
      !(reg_wr && reg_addr == `DSL_OFS_LATCH)
        |=> $stable(write_gate_latch);
  endproperty
  a_latch_keep: assert property (p_latch_keep)
    else $error("latch moved without latch write");

  property p_latch_read;
    @(posedge core_clk) disable iff (srst)
      (reg_rd && reg_addr == `DSL_OFS_LATCH)
        |=> reg_rdata == {$past(write_gate_latch), 7'h00};
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch register read wrong");

  property p_store_open;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && cur_ff.latch && reg_addr == `DSL_OFS_SELECT)
        |=> cur_ff.select == $past(reg_wdata);
  endproperty
  a_store_open: assert property (p_store_open)
    else $error("select not stored while latch set");

  property p_byte_closed;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && !cur_ff.latch && reg_addr == `DSL_OFS_CONV2_BYTE)
        |=> $stable(cur_ff.conv2_byte);
  endproperty
  a_byte_closed: assert property (p_byte_closed)
    else $error("direct byte changed while latch clear");

  property p_rsvd_no_store;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && is_rsvd)
        |=> $stable(cur_ff.select) && $stable(cur_ff.conv2_byte) &&
            $stable(write_gate_latch);
  endproperty
  a_rsvd_no_store: assert property (p_rsvd_no_store)
    else $error("reserved write changed state");

  property p_conv1_direct;
    @(posedge core_clk) disable iff (srst)
      conv1_direct_sel
        |-> conv1_in == conv1_direct_byte;
  endproperty
  a_conv1_direct: assert property (p_conv1_direct)
    else $error("converter one not fed from direct byte");

  property p_conv1_table;
    @(posedge core_clk) disable iff (srst)
      !conv1_direct_sel
        |-> conv1_in == table_one_data;
  endproperty
  a_conv1_table: assert property (p_conv1_table)
    else $error("converter one not fed from table");

  property p_row2_addr;
    @(posedge core_clk) disable iff (srst)
      !table2_direct_row_sel |->
        table_two_addr == (`DSL_TABLE2_BASE + {2'b00, adc_result_bits[7:2]});
  endproperty
  a_row2_addr: assert property (p_row2_addr)
    else $error("table two row not from adc");

  property p_row1_direct;
    @(posedge core_clk) disable iff (srst)
      table1_direct_row_sel |->
        table_one_addr == (`DSL_TABLE1_BASE + {2'b00, table1_direct_row});
  endproperty
  a_row1_direct: assert property (p_row1_direct)
    else $error("table one row not from direct row");
endmodule

/* design/dsl_row_mux.sv */
// Purpose: resolve one converter input byte from table row or direct byte
// Assumes: table read port is combinational
// Notes:   used once per converter
`timescale 1ns/1ns
module dsl_row_mux
  import dsl_pkg::*;
#(
  parameter int ROW_W = 6,
  parameter int DAT_W = 8
) (
  // selects
  input  wire logic             row_direct,
  input  wire logic             byte_direct,
  // sources
  input  wire logic [DAT_W-1:0] adc_value,
  input  wire logic [ROW_W-1:0] direct_row,
  input  wire logic [DAT_W-1:0] direct_byte,
  input  wire logic [DAT_W-1:0] table_base,
  input  wire logic [DAT_W-1:0] table_data,
  // results
  output logic      [DAT_W-1:0] table_addr,
  output logic      [DAT_W-1:0] conv_in
);
  // refuse widths the zero extension below cannot serve
  if (ROW_W >= DAT_W) begin : g_bad_width
    $error("row field must be narrower than data");
  end
  logic [ROW_W-1:0] row;
  always_comb begin
    // upper adc bits pick the row unless the direct row is chosen
    row = row_direct ? direct_row
                     : adc_value[DAT_W-1 -: ROW_W];
    table_addr = table_base + {{(DAT_W-ROW_W){1'b0}}, row};
    // direct byte wins over the table only when selected
    conv_in = byte_direct ? direct_byte : table_data;
  end
endmodule

/* shared/dsl_cfg.svh */
// Purpose: constants for the converter source select and write latch block
// Assumes: byte-wide register port from the serial interface logic
// Notes:   offsets are byte addresses of the control space
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH
`define DSL_OFS_CONV1_ROW   8'h81
`define DSL_OFS_CONV2_ROW   8'h82
`define DSL_OFS_CONV1_BYTE  8'h83
`define DSL_OFS_CONV2_BYTE  8'h84
`define DSL_OFS_SELECT      8'h85
`define DSL_OFS_LATCH       8'h86
`define DSL_OFS_ADC         8'h87
`define DSL_OFS_RSVD_LO     8'h88
`define DSL_OFS_RSVD_HI     8'h8f
`define DSL_TABLE1_BASE     8'h90
`define DSL_TABLE2_BASE     8'hd0
`define DSL_BIT_CONV2_SEL   7
`define DSL_BIT_TABLE2_SEL  6
`define DSL_BIT_CONV1_SEL   5
`define DSL_BIT_TABLE1_SEL  4
`define DSL_BIT_OUT2_HI     3
`define DSL_BIT_OUT2_LO     2
`define DSL_BIT_OUT1_HI     1
`define DSL_BIT_OUT1_LO     0
`define DSL_BIT_LATCH       7
`define DSL_LATCH_SET_VAL   8'h80
`define DSL_LATCH_CLR_VAL   8'h00
`define DSL_RST_BYTE        8'h00
`endif

/* shared/dsl_pkg.sv */
// Purpose: types for the converter source select and write latch block
// Assumes: dsl_cfg.svh holds the numbers
// Notes:   range codes shared by both outputs
package dsl_pkg;
  typedef enum logic [1:0] {
    DSL_RANGE_EXT,
    DSL_RANGE_LOW,
    DSL_RANGE_MID,
    DSL_RANGE_HIGH
  } dsl_range_t;
endpackage

/* test/dsl_ctrl_regs_tb.sv */
// Purpose: self-checking bench for the upper control registers
// Assumes: table memory modelled as a fixed function of its address
// Notes:   ack and read data checked by a monitor against queued notes
`timescale 1ns/1ns
`include "dsl_cfg.svh"
module dsl_ctrl_regs_tb;
  import dsl_pkg::*;
  logic core_clk, srst, reg_wr, reg_rd, reg_wr_ack, latch, vol;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, adc, c1, d2, sel;
  logic [7:0] t1a, t1d, t2a, t2d, conv1, conv2;
  logic [5:0] r1, r2;
  logic       persist, wr_p, rd_p;
  dsl_range_t rng1, rng2;
  int         num_errors, checked;
  logic       ack_q[$];
  logic [7:0] dat_q[$];
  assign t1d = t1a + 8'h11;
  assign t2d = t2a ^ 8'ha5;
  dsl_host_model host (.core_clk(core_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  dsl_ctrl_regs dut (.core_clk(core_clk), .srst(srst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_wr_ack(reg_wr_ack), .write_gate_latch(latch),
    .ctrl_volatility_sel(vol),
    .table1_direct_row(r1), .table2_direct_row(r2),
    .conv1_direct_byte(c1), .adc_result_bits(adc),
    .table_one_addr(t1a), .table_one_data(t1d),
    .table_two_addr(t2a), .table_two_data(t2d),
    .conv1_in(conv1), .conv2_in(conv2), .out1_range(rng1),
    .out2_range(rng2), .conv2_byte_persist(persist));
  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic cmp8(input string n, input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp1(input string n, input logic g, e);
    cmp8(n, {7'h00, g}, {7'h00, e});
  endtask
  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // results appear one edge after the taking edge
  always @(posedge core_clk) begin
    if (wr_p) cmp1("ack", reg_wr_ack, ack_q.pop_front());
    if (rd_p) cmp8("rdata", reg_rdata, dat_q.pop_front());
    wr_p <= reg_wr;
    rd_p <= reg_rd;
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, d, input logic ack);
    ack_q.push_back(ack);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    dat_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic chk_latch(input logic e);
    #1;
    cmp1("latch", latch, e);
  endtask
  // new random sources, then every resolved output
  task automatic chk_conv();
    logic [7:0] a1, a2;
    @(posedge core_clk);
    adc   <= 8'($urandom);
    r1    <= 6'($urandom);
    r2    <= 6'($urandom);
    c1    <= 8'($urandom);
    vol   <= 1'($urandom);
    #1;
    a1 = `DSL_TABLE1_BASE + {2'b00, sel[4] ? r1 : adc[7:2]};
    a2 = `DSL_TABLE2_BASE + {2'b00, sel[6] ? r2 : adc[7:2]};
    cmp8("t1addr", t1a, a1);
    cmp8("t2addr", t2a, a2);
    cmp8("conv1", conv1, sel[5] ? c1 : a1 + 8'h11);
    cmp8("conv2", conv2, sel[7] ? d2 : a2 ^ 8'ha5);
    cmp8("rng1", {6'h00, rng1}, {6'h00, sel[1:0]});
    cmp8("rng2", {6'h00, rng2}, {6'h00, sel[3:2]});
    cmp1("persist", persist, vol);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    {vol, r1, r2, c1, adc, wr_p, rd_p} = '0;
    {sel, d2, num_errors, checked} = '0;
    void'($urandom(26));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    chk_conv();
    chk_latch(1'b0);
    rd(8'h85, 8'h00);
    rd(8'h86, 8'h00);
    wr(8'h84, 8'h5a, 1'b0);
    rd(8'h84, 8'h00);
    wr(8'h86, 8'h55, 1'b1);
    rd(8'h86, 8'h00);
    wr(8'h86, `DSL_LATCH_SET_VAL, 1'b1);
    chk_latch(1'b1);
    rd(8'h86, 8'h80);
    wr(8'h86, 8'h81, 1'b1);
    chk_latch(1'b1);
    d2 = 8'($urandom);
    wr(8'h84, d2, 1'b1);
    rd(8'h84, d2);
    for (int i = 0; i < 16; i++) begin
      sel = {i[3:0], i[1:0], i[3:2]};
      wr(8'h85, sel, 1'b1);
      rd(8'h85, sel);
      chk_conv();
    end
    wr(8'h8a, 8'hff, 1'b1);
    rd(8'h8a, 8'h00);
    rd(8'h87, adc);
    wr(8'h86, `DSL_LATCH_CLR_VAL, 1'b1);
    chk_latch(1'b0);
    wr(8'h85, 8'h00, 1'b0);
    rd(8'h85, sel);
    rd(8'h86, 8'h00);
    // mid-run reset must drop the latch and all stored bytes
    wr(8'h86, `DSL_LATCH_SET_VAL, 1'b1);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    sel = 8'h00;
    d2  = 8'h00;
    chk_latch(1'b0);
    chk_conv();
    rd(8'h85, 8'h00);
    rd(8'h84, 8'h00);
    wr(8'h84, 8'h3c, 1'b0);
    repeat (3) @(posedge core_clk);
    summarize();
  end
endmodule

/* test/dsl_host_model.sv */
// Purpose: host side of the byte register port
// Assumes: one strobe per access, changed just after the rising edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ns
module dsl_host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // ----------------------------------------
  // one access: strobe stands for one edge
  // ----------------------------------------
  // released lines are inverted so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= w;
    reg_rd    <= ~w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule
